// [verilog/autoneg_next_page_rx_status.sv]
`timescale 1ns/10ps
module autoneg_next_page_rx_status #(
  parameter logic [10:0] EEE_MSG_CODE = 11'h00a
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // host register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [1:0]  reg_be_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  output logic             reg_ack_o,
  // received link code words from the auto-negotiation receiver
  input  wire logic        word_valid_i,
  input  wire logic [15:0] word_i,
  input  wire logic        an_restart_i,
  input  wire logic        local_more_pages_i,
  input  wire logic        local_base_toggle_i,
  // toward the auto-negotiation transmitter
  output logic             tx_ack_o,
  output logic             tx_toggle_o,
  output logic             local_eee_100tx_o,
  output logic             page_captured_o,
  output logic             toggle_error_o,
  output logic             exchange_done_o
);

  logic                    accept;
  logic                    consistent;
  logic [15:0]             acc_word;
  autoneg_np_pkg::an_phase_e phase_q;
  autoneg_np_pkg::an_phase_e phase_d;
  logic [15:0]             np_rx_q;
  logic [5:0]              lp_eee_q;
  logic                    loc_100tx_q;
  logic                    eee_pending_q;
  logic                    rx_toggle_q;
  logic                    rx_toggle_valid_q;
  logic                    tx_toggle_q;
  logic                    eee_cap_page;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    // either byte of the 16-bit register selects it
    reg_hit = addr[7:1] == ofs[7:1];
  endfunction

  function automatic logic [5:0] eee_caps(input logic [15:0] w);
    // ordered kr, kx4, kx, 10gt, 1000t, 100tx
    eee_caps = {w[autoneg_np_pkg::UP_KR_POS],
                w[autoneg_np_pkg::UP_KX4_POS],
                w[autoneg_np_pkg::UP_KX_POS],
                w[autoneg_np_pkg::UP_10GT_POS],
                w[autoneg_np_pkg::UP_1000T_POS],
                w[autoneg_np_pkg::UP_100TX_POS]};
  endfunction

  page_consistency u_consistency (
    .clk_i        (clk_i),
    .srst_i       (srst_i),
    .word_valid_i (word_valid_i),
    .word_i       (word_i),
    .accept_o     (accept),
    .consistent_o (consistent),
    .word_o       (acc_word)
  );

  // ack bit position is fixed whatever the page encoding
  assign tx_ack_o = consistent;

  // negotiation phase
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      autoneg_np_pkg::ST_BASE: begin
        if (accept) begin
          if (acc_word[autoneg_np_pkg::MORE_PAGES_POS] || local_more_pages_i) begin
            phase_d = autoneg_np_pkg::ST_NEXT;
          end else begin
            phase_d = autoneg_np_pkg::ST_DONE;
          end
        end
      end
      autoneg_np_pkg::ST_NEXT: begin
        if (accept && !acc_word[autoneg_np_pkg::MORE_PAGES_POS] && !local_more_pages_i) begin
          phase_d = autoneg_np_pkg::ST_DONE;
        end
      end
      autoneg_np_pkg::ST_DONE: begin
        phase_d = autoneg_np_pkg::ST_DONE;
      end
      default: begin
        phase_d = autoneg_np_pkg::ST_BASE;
      end
    endcase
    if (an_restart_i) begin
      phase_d = autoneg_np_pkg::ST_BASE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_q <= autoneg_np_pkg::ST_BASE;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign exchange_done_o = phase_q == autoneg_np_pkg::ST_DONE;

  // received next page capture; one write of all fields so reads stay coherent
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      np_rx_q <= autoneg_np_pkg::PARTNER_NP_RX_RST;
    end else if (accept && phase_q == autoneg_np_pkg::ST_NEXT) begin
      np_rx_q <= acc_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      page_captured_o <= 1'b0;
    end else begin
      page_captured_o <= accept && phase_q == autoneg_np_pkg::ST_NEXT;
    end
  end

  // eee capabilities ride in the unformatted page after the eee message page
  assign eee_cap_page = accept && phase_q == autoneg_np_pkg::ST_NEXT &&
                        !acc_word[autoneg_np_pkg::MESSAGE_PAGE_POS];

  always_ff @(posedge clk_i) begin
    if (srst_i || an_restart_i) begin
      eee_pending_q <= 1'b0;
    end else if (accept && phase_q == autoneg_np_pkg::ST_NEXT) begin
      eee_pending_q <= acc_word[autoneg_np_pkg::MESSAGE_PAGE_POS] &&
                       acc_word[autoneg_np_pkg::CODE_MSB:autoneg_np_pkg::CODE_LSB] ==
                       EEE_MSG_CODE;
    end
  end

  // stale partner abilities are dropped when negotiation restarts
  always_ff @(posedge clk_i) begin
    if (srst_i || an_restart_i) begin
      lp_eee_q <= autoneg_np_pkg::LP_EEE_RST;
    end else if (eee_cap_page && eee_pending_q) begin
      lp_eee_q <= eee_caps(acc_word);
    end
  end

  // partner toggle must flip page to page; first next page against base
  always_ff @(posedge clk_i) begin
    if (srst_i || an_restart_i) begin
      rx_toggle_q       <= 1'b0;
      rx_toggle_valid_q <= 1'b0;
      toggle_error_o    <= 1'b0;
    end else begin
      toggle_error_o <= 1'b0;
      if (accept) begin
        rx_toggle_q       <= acc_word[autoneg_np_pkg::TOGGLE_POS];
        rx_toggle_valid_q <= 1'b1;
        if (phase_q == autoneg_np_pkg::ST_NEXT && rx_toggle_valid_q) begin
          toggle_error_o <= acc_word[autoneg_np_pkg::TOGGLE_POS] == rx_toggle_q;
        end
      end
    end
  end

  // local transmit toggle
  always_ff @(posedge clk_i) begin
    if (srst_i || an_restart_i) begin
      tx_toggle_q <= 1'b0;
    end else if (accept) begin
      if (phase_q == autoneg_np_pkg::ST_BASE) begin
        tx_toggle_q <= ~local_base_toggle_i;
      end else if (phase_q == autoneg_np_pkg::ST_NEXT) begin
        tx_toggle_q <= ~tx_toggle_q;
      end
    end
  end

  assign tx_toggle_o = tx_toggle_q;

  // local 100tx eee advertisement is the only writable bit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      loc_100tx_q <= autoneg_np_pkg::LOC_100TX_RST;
    end else if (reg_wr_i && reg_be_i[0] &&
                 reg_hit(reg_addr_i, autoneg_np_pkg::EEE_PARTNER_ADV_OFS)) begin
      loc_100tx_q <= reg_wdata_i[autoneg_np_pkg::LOC_100TX_POS];
    end
  end

  assign local_eee_100tx_o = loc_100tx_q;

  // register read path; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
      reg_ack_o   <= 1'b0;
    end else begin
      reg_ack_o <= reg_rd_i || reg_wr_i;
      if (reg_rd_i) begin
        reg_rdata_o <= 16'h0000;
        if (reg_hit(reg_addr_i, autoneg_np_pkg::PARTNER_NP_RX_OFS)) begin
          reg_rdata_o <= np_rx_q;
        end else if (reg_hit(reg_addr_i, autoneg_np_pkg::EEE_PARTNER_ADV_OFS)) begin
          reg_rdata_o[autoneg_np_pkg::ADV_RESERVED_POS] <= 1'b0;
          reg_rdata_o[autoneg_np_pkg::LP_KR_POS]    <= lp_eee_q[5];
          reg_rdata_o[autoneg_np_pkg::LP_KX4_POS]   <= lp_eee_q[4];
          reg_rdata_o[autoneg_np_pkg::LP_KX_POS]    <= lp_eee_q[3];
          reg_rdata_o[autoneg_np_pkg::LP_10GT_POS]  <= lp_eee_q[2];
          reg_rdata_o[autoneg_np_pkg::LP_1000T_POS] <= lp_eee_q[1];
          reg_rdata_o[autoneg_np_pkg::LP_100TX_POS] <= lp_eee_q[0];
          reg_rdata_o[autoneg_np_pkg::LOC_100TX_POS] <= loc_100tx_q;
        end
      end
    end
  end

endmodule

// [verilog/autoneg_np_pkg.sv]
package autoneg_np_pkg;

  // register byte offsets; each register is 16 bits and spans two bytes
  localparam logic [7:0]  PARTNER_NP_RX_OFS     = 8'hde;
  localparam logic [7:0]  EEE_PARTNER_ADV_OFS   = 8'he0;

  // page field positions
  localparam int          MORE_PAGES_POS        = 15;
  localparam int          ACK_POS               = 14;
  localparam int          MESSAGE_PAGE_POS      = 13;
  localparam int          CAN_COMPLY_POS        = 12;
  localparam int          TOGGLE_POS            = 11;
  localparam int          CODE_MSB              = 10;
  localparam int          CODE_LSB              = 0;

  // advertisement register field positions
  localparam int          ADV_RESERVED_POS      = 15;
  localparam int          LP_KR_POS             = 14;
  localparam int          LP_KX4_POS            = 13;
  localparam int          LP_KX_POS             = 12;
  localparam int          LP_10GT_POS           = 11;
  localparam int          LP_1000T_POS          = 10;
  localparam int          LP_100TX_POS          = 9;
  localparam int          LOC_KR_POS            = 6;
  localparam int          LOC_KX4_POS           = 5;
  localparam int          LOC_KX_POS            = 4;
  localparam int          LOC_10GT_POS          = 3;
  localparam int          LOC_1000T_POS         = 2;
  localparam int          LOC_100TX_POS         = 1;

  // positions of capability bits inside the partner's unformatted page
  localparam int          UP_100TX_POS          = 1;
  localparam int          UP_1000T_POS          = 2;
  localparam int          UP_10GT_POS           = 3;
  localparam int          UP_KX_POS             = 4;
  localparam int          UP_KX4_POS            = 5;
  localparam int          UP_KR_POS             = 6;

  // reset values
  localparam logic [15:0] PARTNER_NP_RX_RST     = 16'h8000;
  localparam logic [5:0]  LP_EEE_RST            = 6'h00;
  localparam logic        LOC_100TX_RST         = 1'h1;

  // consecutive consistent words before a page counts as received
  localparam logic [1:0]  CONSIST_COUNT         = 2'h3;

  typedef enum logic [1:0] {
    ST_BASE = 2'b00,
    ST_NEXT = 2'b01,
    ST_DONE = 2'b10
  } an_phase_e;

endpackage

// [verilog/page_consistency.sv]
`timescale 1ns/10ps
module page_consistency (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        word_valid_i,
  input  wire logic [15:0] word_i,
  output logic             accept_o,
  output logic             consistent_o,
  output logic [15:0]      word_o
);

  logic [15:0] last_q;
  logic [1:0]  cnt_q;
  logic        same;

  // the acknowledge bit is ignored when comparing bursts
  assign same = ((last_q ^ word_i) & ~(16'h0001 << autoneg_np_pkg::ACK_POS)) == 16'h0000;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      last_q <= 16'h0000;
      cnt_q  <= 2'h0;
    end else if (word_valid_i) begin
      last_q <= word_i;
      if (!same || cnt_q == 2'h0) begin
        cnt_q <= 2'h1;
      end else if (cnt_q != autoneg_np_pkg::CONSIST_COUNT) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  // one pulse per page: saturating counter stops repeat accepts
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      accept_o <= 1'b0;
      word_o   <= 16'h0000;
    end else begin
      accept_o <= word_valid_i && same &&
                  cnt_q == autoneg_np_pkg::CONSIST_COUNT - 2'h1;
      if (word_valid_i) begin
        word_o <= word_i;
      end
    end
  end

  assign consistent_o = cnt_q == autoneg_np_pkg::CONSIST_COUNT;

endmodule

// [tb/link_partner_model.sv]
`timescale 1ns/10ps
module link_partner_model (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        send_i,
  input  wire logic [15:0] page_i,
  output logic             word_valid_o,
  output logic [15:0]      word_o
);
  logic [1:0] left_q;
  // one burst per cycle, three in a row, so the page is judged consistent
  always_ff @(posedge clk_i) begin
    if (srst_i) left_q <= 2'h0;
    else if (send_i) left_q <= 2'h3;
    else if (left_q != 2'h0) left_q <= left_q - 2'h1;
  end
  assign word_valid_o = (left_q != 2'h0);
  // page_i carries ack in bit 14 and toggle in bit 11 as the caller sets them
  // idle line shows the inverse so a stale page cannot pass for a fresh one
  assign word_o = word_valid_o ? page_i : ~page_i;
endmodule

// [tb/autoneg_next_page_rx_status_assertions.sv]
`timescale 1ns/10ps
module autoneg_np_checker (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_ack_o,
  input wire logic        word_valid_i,
  input wire logic [15:0] word_i,
  input wire logic        an_restart_i,
  input wire logic        tx_ack_o,
  input wire logic        tx_toggle_o,
  input wire logic        page_captured_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [15:0] prev_q;
  logic        same;
  always_ff @(posedge clk_i) begin
    if (word_valid_i) prev_q <= word_i;
  end
  // ack bit left out of the consistency test
  assign same = ({word_i[15], word_i[13:0]} == {prev_q[15], prev_q[13:0]});
  ack_pulse_a: assert property ((reg_rd_i || reg_wr_i) |=> reg_ack_o) else $error("no ack");
  ack_quiet_a: assert property (!(reg_rd_i || reg_wr_i) |=> !reg_ack_o) else $error("stray ack");
  unmapped_zero_a: assert property (reg_rd_i && reg_addr_i[7:1] != 7'h6f && reg_addr_i[7:1] != 7'h70
    |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
  adv_reserved_a: assert property (
    reg_rd_i && reg_addr_i[7:1] == 7'h70 |=> reg_rdata_o[15] == 1'b0 &&
    reg_rdata_o[8:7] == 2'h0 && reg_rdata_o[0] == 1'b0) else $error("reserved bit set");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata moved");
  ack_three_a: assert property (
    (word_valid_i && !an_restart_i) ##1 (word_valid_i && same && !an_restart_i) [*2]
    |=> tx_ack_o) else $error("no tx ack");
  ack_cause_a: assert property ($rose(tx_ack_o) |-> $past(word_valid_i)) else $error("early ack");
  capture_order_a: assert property (page_captured_o |-> $past(tx_ack_o)) else $error("bad capture");
  toggle_flip_a: assert property (page_captured_o |-> tx_toggle_o != $past(tx_toggle_o))
    else $error("toggle held");
  page_c: cover property (page_captured_o);
  ack_c: cover property ($rose(tx_ack_o));
  adv_rd_c: cover property (reg_rd_i && reg_addr_i == 8'he0);
endmodule
bind autoneg_next_page_rx_status autoneg_np_checker u_chk (.clk_i, .srst_i, .reg_addr_i, .reg_rd_i,
  .reg_wr_i, .reg_rdata_o, .reg_ack_o, .word_valid_i, .word_i, .an_restart_i, .tx_ack_o,
  .tx_toggle_o, .page_captured_o);

// [tb/autoneg_next_page_rx_status_bench.sv]
`timescale 1ns/10ps
module autoneg_next_page_rx_status_bench;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [1:0]  be = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        ack;
  logic        send = 1'b0;
  logic [15:0] page = 16'h0000;
  logic        wvalid;
  logic [15:0] word;
  logic        restart = 1'b0;
  logic        more = 1'b1;
  logic        base_t = 1'b1;
  logic        tx_ack;
  logic        tx_tog;
  logic        cap;
  logic        terr;
  logic        loc_eee;
  logic        done;
  int          fail_count = 0;
  int          checks_done = 0;
  int          caps = 0;
  int          terrs = 0;
  int          cycles = 0;

  autoneg_next_page_rx_status DUT (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_be_i(be), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_ack_o(ack), .word_valid_i(wvalid), .word_i(word), .an_restart_i(restart),
    .local_more_pages_i(more), .local_base_toggle_i(base_t), .tx_ack_o(tx_ack),
    .tx_toggle_o(tx_tog), .local_eee_100tx_o(loc_eee), .page_captured_o(cap),
    .toggle_error_o(terr), .exchange_done_o(done));
  link_partner_model partner (.clk_i(clk_i), .srst_i(srst_i), .send_i(send), .page_i(page),
    .word_valid_o(wvalid), .word_o(word));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cap === 1'b1) caps++;
    if (terr === 1'b1) terrs++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobe is one cycle; an edge passes before the next call may raise it again
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    addr = a;
    rd = 1'b1;
    tick();
    rd = 1'b0;
    check({15'h0000, ack}, 16'h0001);
    check(rdata, exp);
    tick();
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    addr = a;
    be = b;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
    check({15'h0000, ack}, 16'h0001);
    tick();
  endtask
  // partner sends one page; waits past capture, then tx ack must stand
  task automatic send_page(input logic [15:0] w);
    page = w;
    send = 1'b1;
    tick();
    send = 1'b0;
    repeat (6) tick();
    check({15'h0000, tx_ack}, 16'h0001);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (8) tick();
    srst_i = 1'b0;
    rd_reg(8'hde, 16'h8000);
    rd_reg(8'he0, 16'h0002);
    rd_reg(8'h10, 16'h0000);
    wr_reg(8'hde, 2'h3, 16'h1234);
    rd_reg(8'hdf, 16'h8000);
    wr_reg(8'he0, 2'h3, 16'hffff);
    rd_reg(8'he0, 16'h0002);
    wr_reg(8'he0, 2'h1, 16'h0000);
    rd_reg(8'he0, 16'h0000);
    wr_reg(8'he0, 2'h2, 16'h0002);
    rd_reg(8'he1, 16'h0000);
    wr_reg(8'he0, 2'h1, 16'h0002);
    $display("test registers done");
    send_page(16'hc801);
    rd_reg(8'hde, 16'h8000);
    check({15'h0000, tx_tog}, 16'h0000);
    send_page(16'hf00a);
    rd_reg(8'hde, 16'hf00a);
    check({15'h0000, tx_tog}, 16'h0001);
    more = 1'b0;
    send_page(16'h4872);
    rd_reg(8'hde, 16'h4872);
    rd_reg(8'he0, 16'h7202);
    check(16'(caps), 16'h0002);
    check(16'(terrs), 16'h0000);
    check({15'h0000, done}, 16'h0001);
    $display("test exchange done");
    restart = 1'b1;
    tick();
    restart = 1'b0;
    check({15'h0000, done}, 16'h0000);
    rd_reg(8'he0, 16'h0002);
    base_t = 1'b0;
    more = 1'b1;
    send_page(16'h8001);
    check({15'h0000, tx_tog}, 16'h0001);
    // toggle should be one here: zero must be flagged
    send_page(16'h8123);
    check(16'(terrs), 16'h0001);
    $display("test restart done");
    wr_reg(8'he0, 2'h1, 16'h0000);
    check({15'h0000, loc_eee}, 16'h0000);
    // mid-run reset must bring back every reset value
    srst_i = 1'b1;
    repeat (2) tick();
    srst_i = 1'b0;
    check({15'h0000, loc_eee}, 16'h0001);
    check({15'h0000, done}, 16'h0000);
    rd_reg(8'hde, 16'h8000);
    rd_reg(8'he0, 16'h0002);
    $display("test reset done");
    stop_test();
  end
endmodule
